/* rtl/fq_flash_query.sv */
`timescale 1ns/1ps
// Function
// - query byte placed on low data lines
// - upper data byte reads zero in query
// - query offsets are word addresses, signature 10h
// - words 10h-12h return Q, R, Y
// - set ids and table pointer at 13h-18h
// - words 01h-0Fh reserved for vendor data
// - system interface 1Bh, geometry at 27h
// - query command switches reads to database
// - address-valid low after write starts read
// - word program 115/50 us, max 230
// - full buffer program 1.02 ms, max 2.05
// - timeout fields are power-of-two exponents
module fq_flash_query
    import fq_pkg::*;
#(
    parameter int AW             = 24,
    parameter int PROG_FIRST_CYC = FQ_PROG_FIRST_CYC,
    parameter int PROG_NEXT_CYC  = FQ_PROG_NEXT_CYC,
    parameter int BUF_PROG_CYC   = FQ_BUF_PROG_CYC
) (
    // clock, reset, enable
    input  wire logic          mclk,
    input  wire logic          nrst,
    input  wire logic          en,
    // flash bus pins
    input  wire logic          chip_en_n,
    input  wire logic          out_en_n,
    input  wire logic          wr_en_n,
    input  wire logic          address_valid_n,
    input  wire logic [AW-1:0] addr,
    input  wire logic [15:0]   dq_in,
    output logic      [15:0]   dq_out,
    output logic               dq_oe,
    // array side
    input  wire logic [15:0]   array_rdata,
    output logic      [AW-1:0] array_raddr,
    output logic               array_wr,
    output logic      [AW-1:0] array_waddr,
    output logic      [15:0]   array_wdata,
    output logic               busy
);

    typedef struct packed {
        logic            ce_m, ce_s, oe_m, oe_s, we_m, we_s, adv_m, adv_s;
        logic [AW-1:0]   addr_m, addr_s;
        logic [15:0]     dq_m, dq_s;
        logic            we_d;
        fq_state_t       state;
        fq_mode_t        mode;
        logic            seq_prog;
        logic [FQ_BCNT_W-1:0] bcnt;
        logic [FQ_TMR_W-1:0]  tmr;
        logic [AW-1:0]   rd_addr;
        logic [15:0]     dq_out;
        logic            dq_oe;
        logic            wr;
        logic [AW-1:0]   waddr;
        logic [15:0]     wdata;
        logic            busy;
    } fq_state_all_t;

    fq_state_all_t r;
    fq_state_all_t next_r;
    logic          rst_m;
    logic          rst_s;
    logic          wr_done;
    fq_rom_if      rif();

    function automatic logic is_wprog(input logic [7:0] c);
        return (c == FQ_CMD_WPROG) || (c == FQ_CMD_WPROG_ALT);
    endfunction

    // reset release through two flops so every flop leaves reset together
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rst_m <= 1'b0;
            rst_s <= 1'b0;
        end else begin
            rst_m <= 1'b1;
            rst_s <= rst_m;
        end
    end

    fq_query_rom u_rom (
        .mclk  (mclk),
        .rst_n (rst_s),
        .en    (en),
        .rif   (rif)
    );

    // database window is the low 64 words; anything above reads zero
    assign rif.addr = r.rd_addr[FQ_QRY_ADDR_W-1:0];
    assign rif.hit  = (r.rd_addr[AW-1:FQ_QRY_ADDR_W] == '0);
    assign wr_done  = r.we_d && !r.we_s && r.ce_s;

    always_comb begin
        next_r = r;
        // pins held as active-high levels, two flops each; addr and dq cross as
        // whole words, which is safe only because a write takes them three edges
        // after the strobe rises, long after the host has let them settle
        next_r.ce_m   = !chip_en_n;
        next_r.ce_s   = r.ce_m;
        next_r.oe_m   = !out_en_n;
        next_r.oe_s   = r.oe_m;
        next_r.we_m   = !wr_en_n;
        next_r.we_s   = r.we_m;
        next_r.adv_m  = !address_valid_n;
        next_r.adv_s  = r.adv_m;
        next_r.addr_m = addr;
        next_r.addr_s = r.addr_m;
        next_r.dq_m   = dq_in;
        next_r.dq_s   = r.dq_m;
        next_r.we_d   = r.we_s;
        next_r.wr     = 1'b0;

        // a strobe still low when the write ends opens a new read cycle
        // (the address follows the pins whenever that strobe is low and no write strobe is seen)
        if (r.adv_s && !r.we_s) begin
            next_r.rd_addr = r.addr_s;
        end

        // program timer; the typical figures stay under the worst case
        if (r.state == FQ_BUSY) begin
            next_r.tmr = r.tmr - 1'b1;
            if (r.tmr <= FQ_TMR_W'(1)) begin
                next_r.state = FQ_IDLE;
            end
        end

        // command and data writes, taken on the rising write strobe
        if (wr_done) begin
            unique case (r.state)
                FQ_IDLE, FQ_BUSY: begin
                    if (r.dq_s[7:0] == FQ_CMD_QUERY) begin
                        next_r.mode = FQ_MODE_QUERY;
                    end else if (r.dq_s[7:0] == FQ_CMD_ARRAY) begin
                        next_r.mode = FQ_MODE_ARRAY;
                    end else if (r.dq_s[7:0] == FQ_CMD_STATUS) begin
                        next_r.mode = FQ_MODE_STATUS;
                    end
                    if (r.state == FQ_IDLE) begin
                        if (is_wprog(r.dq_s[7:0])) begin
                            next_r.state = FQ_PROG_DAT;
                        end else if (r.dq_s[7:0] == FQ_CMD_BPROG) begin
                            next_r.state = FQ_BUF_CNT;
                        end else begin
                            next_r.seq_prog = 1'b0; // a foreign command ends a program run
                        end
                    end
                end
                FQ_PROG_DAT: begin
                    next_r.wr       = 1'b1;
                    next_r.waddr    = r.addr_s;
                    next_r.wdata    = r.dq_s;
                    next_r.tmr      = r.seq_prog ? FQ_TMR_W'(PROG_NEXT_CYC)
                                                 : FQ_TMR_W'(PROG_FIRST_CYC);
                    next_r.seq_prog = 1'b1;
                    next_r.mode     = FQ_MODE_STATUS;
                    next_r.state    = FQ_BUSY;
                end
                FQ_BUF_CNT: begin
                    next_r.bcnt  = r.dq_s[FQ_BCNT_W-1:0]; // count minus one, cut to its low nine bits
                    next_r.state = FQ_BUF_DAT;
                end
                FQ_BUF_DAT: begin
                    // each loaded word goes straight to the array; no buffer is kept
                    next_r.wr    = 1'b1;
                    next_r.waddr = r.addr_s;
                    next_r.wdata = r.dq_s;
                    next_r.bcnt  = r.bcnt - 1'b1;
                    if (r.bcnt == '0) begin
                        next_r.state = FQ_BUF_CONF;
                    end
                end
                FQ_BUF_CONF: begin
                    next_r.mode = FQ_MODE_STATUS;
                    if (r.dq_s[7:0] == FQ_CMD_CONFIRM) begin
                        next_r.tmr   = FQ_TMR_W'(BUF_PROG_CYC);
                        next_r.state = FQ_BUSY;
                    end else begin
                        next_r.state = FQ_IDLE; // bad confirm: no busy, loaded words stay
                    end
                end
                default: next_r.state = FQ_IDLE;
            endcase
        end

        // read data: query words only touch the table, never the array
        next_r.dq_oe = r.ce_s && r.oe_s && !r.we_s;
        unique case (r.mode)
            FQ_MODE_QUERY:  next_r.dq_out = {8'h00, rif.rdata};
            FQ_MODE_STATUS: begin
                // only the ready flag is defined; every other status bit reads zero
                next_r.dq_out                   = 16'h0000;
                next_r.dq_out[FQ_STS_READY_BIT] = (r.state != FQ_BUSY);
            end
            FQ_MODE_ARRAY:  next_r.dq_out = array_rdata;
            default:        next_r.dq_out = 16'h0000;
        endcase

        // busy has its own flop so the pin never shows a decode of state bits
        next_r.busy = (next_r.state == FQ_BUSY);
    end

    always_ff @(posedge mclk or negedge rst_s) begin
        if (!rst_s) begin
            r <= '0;
        end else if (en) begin
            r <= next_r;
        end
    end

    // outputs straight from the state flops
    assign dq_out      = r.dq_out;
    assign dq_oe       = r.dq_oe;
    assign array_raddr = r.rd_addr;
    assign array_wr    = r.wr;
    assign array_waddr = r.waddr;
    assign array_wdata = r.wdata;
    assign busy        = r.busy;

endmodule

/* rtl/fq_pkg.sv */
package fq_pkg;

    // bus clock
    localparam int FQ_CLK_NS = 25;

    // program durations in ns (typical, and the worst case a word or a full buffer may take)
    localparam int FQ_PROG_FIRST_NS = 115000;
    localparam int FQ_PROG_NEXT_NS  = 50000;
    localparam int FQ_PROG_MAX_NS   = 230000;
    localparam int FQ_BUF_PROG_NS   = 1020000;
    localparam int FQ_BUF_MAX_NS    = 2050000;

    // cycle counts derived from the durations
    localparam int FQ_PROG_FIRST_CYC = FQ_PROG_FIRST_NS / FQ_CLK_NS;
    localparam int FQ_PROG_NEXT_CYC  = FQ_PROG_NEXT_NS / FQ_CLK_NS;
    localparam int FQ_PROG_MAX_CYC   = FQ_PROG_MAX_NS / FQ_CLK_NS;
    localparam int FQ_BUF_PROG_CYC   = FQ_BUF_PROG_NS / FQ_CLK_NS;
    localparam int FQ_BUF_MAX_CYC    = FQ_BUF_MAX_NS / FQ_CLK_NS;
    localparam int FQ_TMR_W          = 22;

    // write buffer
    localparam int FQ_BUF_WORDS = 512;
    localparam int FQ_BCNT_W    = 9;

    // command codes on the low data byte
    localparam logic [7:0] FQ_CMD_QUERY     = 8'h98;
    localparam logic [7:0] FQ_CMD_ARRAY     = 8'hff;
    localparam logic [7:0] FQ_CMD_STATUS    = 8'h70;
    localparam logic [7:0] FQ_CMD_WPROG     = 8'h40;
    localparam logic [7:0] FQ_CMD_WPROG_ALT = 8'h10;
    localparam logic [7:0] FQ_CMD_BPROG     = 8'he8;
    localparam logic [7:0] FQ_CMD_CONFIRM   = 8'hd0;

    // query database layout (word addresses)
    localparam int FQ_QRY_ADDR_W    = 6;
    localparam logic [5:0] FQ_QRY_VENDOR_LO = 6'h01;
    localparam logic [5:0] FQ_QRY_VENDOR_HI = 6'h0f;
    localparam logic [5:0] FQ_QRY_ID_BASE   = 6'h10;
    localparam logic [5:0] FQ_QRY_SYS_BASE  = 6'h1b;
    localparam logic [5:0] FQ_QRY_GEOM_BASE = 6'h27;
    localparam logic [5:0] FQ_QRY_LAST      = 6'h26;
    localparam int FQ_QRY_LEN = 23;

    // contents from 10h to 26h: signature, set ids, table pointer, system interface
    localparam logic [0:FQ_QRY_LEN-1][7:0] FQ_QRY_DATA = {
        8'h51, 8'h52, 8'h59,                 // signature
        8'h00, 8'h02,                        // primary set id, low first
        8'h0a, 8'h01,                        // primary extended table address
        8'h00, 8'h00,                        // alternate set id
        8'h00, 8'h00,                        // secondary table address
        8'h17, 8'h20, 8'h85, 8'h95,          // supply limits
        8'h06, 8'h0a, 8'h0a, 8'h00,          // typical timeouts, 2^n units
        8'h02, 8'h02, 8'h02, 8'h00           // maximum timeouts, 2^n times typical
    };

    // status byte ready bit
    localparam int FQ_STS_READY_BIT = 7;

    typedef enum logic [2:0] {
        FQ_IDLE     = 3'b000,
        FQ_PROG_DAT = 3'b001,
        FQ_BUF_CNT  = 3'b010,
        FQ_BUF_DAT  = 3'b011,
        FQ_BUF_CONF = 3'b100,
        FQ_BUSY     = 3'b101
    } fq_state_t;

    typedef enum logic [1:0] {
        FQ_MODE_ARRAY  = 2'b00,
        FQ_MODE_QUERY  = 2'b01,
        FQ_MODE_STATUS = 2'b10
    } fq_mode_t;

endpackage

/* rtl/fq_rom_if.sv */
`timescale 1ns/1ps
interface fq_rom_if;
    import fq_pkg::*;
    logic [FQ_QRY_ADDR_W-1:0] addr;
    logic                     hit;
    logic [7:0]               rdata;
    modport ctrl (output addr, output hit, input rdata);
    modport rom  (input addr, input hit, output rdata);
endinterface

/* rtl/fq_query_rom.sv */
`timescale 1ns/1ps
module fq_query_rom
    import fq_pkg::*;
(
    // clocking
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic en,
    // lookup port
    fq_rom_if.rom    rif
);

    typedef struct packed {
        logic [7:0] q;
    } fq_rom_state_t;

    fq_rom_state_t r;
    fq_rom_state_t next_r;

    // vendor words 01h-0Fh and geometry from 27h up read as zero here
    always_comb begin
        next_r.q = 8'h00;
        if (rif.hit && rif.addr >= FQ_QRY_ID_BASE && rif.addr <= FQ_QRY_LAST) begin
            next_r.q = FQ_QRY_DATA[5'(rif.addr - FQ_QRY_ID_BASE)];
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else if (en) begin
            r <= next_r;
        end
    end

    assign rif.rdata = r.q;

endmodule

/* test/fq_flash_query_sva.sv */
`timescale 1ns/1ps
module fq_flash_query_sva
    import fq_pkg::*;
#(
    parameter int AW  = 24,
    parameter int BUF = FQ_BUF_PROG_CYC
) (
    // clock and reset
    input wire logic          mclk,
    input wire logic          nrst,
    // pins
    input wire logic          chip_en_n,
    input wire logic          out_en_n,
    input wire logic          wr_en_n,
    input wire logic          dq_oe,
    // array side
    input wire logic          array_wr,
    input wire logic [AW-1:0] array_waddr,
    input wire logic [15:0]   array_wdata,
    input wire logic          busy
);
    logic [31:0] busy_cnt;
    // busy run length, too long for a repetition count
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) busy_cnt <= '0;
        else busy_cnt <= busy ? busy_cnt + 32'h1 : 32'h0;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    // a read held long enough to cross the pin synchronisers
    sequence s_read_held;
        (!chip_en_n && !out_en_n && wr_en_n) [*5];
    endsequence
    sequence s_prog_done;
        array_wr ##1 !array_wr;
    endsequence
    a_read_drives: assert property (s_read_held |-> dq_oe) else $error("no drive on read");
    a_oe_quiet: assert property (out_en_n [*5] |-> !dq_oe) else $error("drive without oe");
    a_write_quiet: assert property (!wr_en_n [*3] |-> ##1 !dq_oe) else $error("drive in write");
    // buffer loads write without busy, so only writes during busy are ruled out
    a_prog_busy: assert property (array_wr |-> !$past(busy)) else $error("program write while busy");
    a_prog_hold: assert property (s_prog_done |-> $stable(array_waddr) && $stable(array_wdata))
        else $error("program word not held");
    a_busy_min: assert property ($rose(busy) |-> busy [*8]) else $error("busy too short");
    a_busy_max: assert property (busy_cnt <= BUF + 1) else $error("busy too long");
    a_idle_nowrite: assert property ((wr_en_n && !busy) [*8] |-> !array_wr)
        else $error("array write without strobe");
endmodule
bind fq_flash_query fq_flash_query_sva #(.AW(AW), .BUF(BUF_PROG_CYC)) u_fq_flash_query_sva (
    .mclk(mclk), .nrst(nrst), .chip_en_n(chip_en_n), .out_en_n(out_en_n), .wr_en_n(wr_en_n), .dq_oe(dq_oe),
    .array_wr(array_wr), .array_waddr(array_waddr), .array_wdata(array_wdata), .busy(busy));

/* test/fq_array_model.sv */
`timescale 1ns/1ps
module fq_array_model (
    // clock
    input  wire logic        mclk,
    // read port
    input  wire logic [23:0] raddr,
    output logic      [15:0] rdata,
    // program port
    input  wire logic        wr,
    input  wire logic [23:0] waddr,
    input  wire logic [15:0] wdata
);
    logic [15:0] mem [64];
    // each word starts distinct so a wrong address shows
    initial for (int i = 0; i < 64; i++) mem[i] = 16'hc300 ^ 16'(i);
    assign rdata = mem[raddr[5:0]];
    // programming only clears bits, as a real cell does
    always @(posedge mclk) if (wr) mem[waddr[5:0]] <= mem[waddr[5:0]] & wdata;
endmodule

/* test/fq_flash_query_test.sv */
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin n_fail++; \
    $display("[FAIL] %0t got %h exp %h", $time, (got), (exp)); end end
module fq_flash_query_test;
    import fq_pkg::*;
    localparam int PF = 20;
    localparam int PN = 10;
    localparam int PB = 40;
    logic        mclk, nrst, en, chip_en_n, out_en_n, wr_en_n, address_valid_n, dq_oe, array_wr, busy;
    logic [23:0] addr, array_raddr, array_waddr;
    logic [15:0] dq_in, dq_out, array_rdata, array_wdata, q;
    int          n_fail, n_compared, busy_run;
    // short program times keep the run brief
    fq_flash_query #(.PROG_FIRST_CYC(PF), .PROG_NEXT_CYC(PN), .BUF_PROG_CYC(PB)) u_fq_flash_query (
        .mclk(mclk), .nrst(nrst), .en(en), .chip_en_n(chip_en_n), .out_en_n(out_en_n), .wr_en_n(wr_en_n),
        .address_valid_n(address_valid_n), .addr(addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
        .array_rdata(array_rdata), .array_raddr(array_raddr), .array_wr(array_wr),
        .array_waddr(array_waddr), .array_wdata(array_wdata), .busy(busy));
    fq_array_model u_fq_array_model (.mclk(mclk), .raddr(array_raddr), .rdata(array_rdata), .wr(array_wr),
        .waddr(array_waddr), .wdata(array_wdata));
    // 40 MHz clock
    initial forever #12.5 mclk = ~mclk;
    // busy cycles of the operation under way
    always @(posedge mclk) if (busy === 1'b1) busy_run++;
    task automatic step(int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask
    // one write; strobe phases long enough for the pin synchronisers
    task automatic wr(logic [23:0] a, logic [15:0] d);
        {addr, dq_in} = {a, d};
        {chip_en_n, wr_en_n} = 2'b00;
        step(3);
        wr_en_n = 1'b1;
        step(2);
        chip_en_n = 1'b1;
        step(4);
    endtask
    // one read; address valid stays low so the address follows
    task automatic rd(logic [23:0] a);
        addr = a;
        {chip_en_n, out_en_n} = 2'b00;
        step(8);
        `CHK(dq_oe, 1'b1)
        q = dq_out;
        {chip_en_n, out_en_n} = 2'b11;
        step(3);
    endtask
    // bounded wait for the end of busy, then judge its length
    task automatic wait_idle(int exp);
        for (int i = 0; i < 300 && busy !== 1'b0; i++) step(1);
        if (busy !== 1'b0) begin
            n_fail++;
            final_report();
        end else begin
            `CHK(busy_run >= exp && busy_run <= exp + 1, 1'b1)
        end
    endtask
    // database over every word address, entered with address valid held low
    task automatic t_query();
        logic [7:0]  id [9];
        logic [15:0] e;
        id = '{8'h51, 8'h52, 8'h59, 8'h00, 8'h02, 8'h0a, 8'h01, 8'h00, 8'h00};
        address_valid_n = 1'b0;
        wr(24'h10, 16'h0098);
        rd(24'h10);
        `CHK(q, 16'h0051)
        for (int a = 0; a < 64; a++) begin
            e = 16'h0000;
            if (a >= 16 && a < 25) e = {8'h00, id[a-16]};
            if (a >= 25 && a < 39) e = {8'h00, FQ_QRY_DATA[a-16]};
            rd(24'(a));
            `CHK(q, e)
        end
        rd(24'h10);
        `CHK(q, 16'h0051)
    endtask
    // back to array, then two word programs: first and later durations
    task automatic t_prog();
        wr(24'h0, 16'h00ff);
        rd(24'h05);
        `CHK(q, 16'hc305)
        wr(24'h0, 16'h0040);
        busy_run = 0;
        wr(24'h07, 16'h1234);
        rd(24'h07);
        `CHK(q, 16'h0000)
        wait_idle(PF);
        rd(24'h07);
        `CHK(q, 16'h0080)
        wr(24'h0, 16'h0010);
        busy_run = 0;
        wr(24'h08, 16'h0ff0);
        wait_idle(PN);
    endtask
    // two-word buffered program, then the word is read back
    task automatic t_buf();
        wr(24'h20, 16'h00e8);
        wr(24'h20, 16'h0001);
        wr(24'h20, 16'h5a5a);
        wr(24'h21, 16'h0f0f);
        busy_run = 0;
        wr(24'h20, 16'h00d0);
        wait_idle(PB);
        wr(24'h0, 16'h00ff);
        rd(24'h21);
        `CHK(q, 16'hc321 & 16'h0f0f)
        rd(24'h07);
        `CHK(q, 16'hc307 & 16'h1234)
    endtask
    // frozen clock enable hides a query command, then a status read
    task automatic t_freeze();
        en = 1'b0;
        wr(24'h0, 16'h0098);
        en = 1'b1;
        rd(24'h05);
        `CHK(q, 16'hc305)
        wr(24'h0, 16'h0070);
        rd(24'h05);
        `CHK(q, 16'h0080)
    endtask
    // reset in mid-run leaves query mode and returns to array reads
    task automatic t_reset();
        wr(24'h0, 16'h0098);
        rd(24'h10);
        `CHK(q, 16'h0051)
        nrst = 1'b0;
        step(5);
        nrst = 1'b1;
        step(6);
        rd(24'h05);
        `CHK(q, 16'hc305)
    endtask
    task automatic final_report();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // reset for five cycles with all pins inactive
    initial begin
        {mclk, chip_en_n, out_en_n, wr_en_n, address_valid_n, nrst, en} = 7'b0111101;
        {addr, dq_in, n_fail, n_compared, busy_run} = '0;
        step(5);
        nrst = 1'b1;
        step(6);
        t_query();
        t_prog();
        t_buf();
        t_freeze();
        t_reset();
        final_report();
    end
endmodule
